// File: bvs_params.svh
// Offsets, field positions, reset values and timing for the voltage control.
// Assumes a 250 MHz core clock; included by the control, the I2C host and the bench.
`ifndef BVS_PARAMS_SVH
`define BVS_PARAMS_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define BVS_OFF_RESTORE_CFG 8'h25
`define BVS_OFF_IRQ_CFG_A 8'h33
`define BVS_OFF_IRQ_CFG_B 8'h34
`define BVS_OFF_IRQ_CFG_C 8'h35
`define BVS_OFF_V0 8'h48
`define BVS_OFF_MODE0 8'h49
`define BVS_OFF_V1 8'h4a
`define BVS_OFF_MODE1 8'h4b
`define BVS_OFF_SEL 8'h52
`define BVS_OFF_SLEW 8'h54

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define BVS_RST_DBNC_MSB 2
`define BVS_RST_CONV1_EN 3
`define BVS_MODE_FORCED_CONTINUOUS 5
`define BVS_MODE_ENABLE 0
`define BVS_SEL_POL 2
`define BVS_SEL_SW0 2'b00
`define BVS_SEL_SW1 2'b01
`define BVS_SEL_PIN 2'b10

// ---------------------------------------------------------------
// Reset and factory values
// ---------------------------------------------------------------
`define BVS_RESTORE_CFG_RST 8'h00
`define BVS_IRQ_CFG_RST 8'h00
`define BVS_V0_DEF 8'h64
`define BVS_V1_DEF 8'h64
`define BVS_MODE_DEF 8'h01
`define BVS_SEL_DEF 8'h00
`define BVS_SLEW_DEF 8'h00

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define BVS_CLK_MHZ 250
`define BVS_DBNC_TIME_US 100
`define BVS_PWM_HOLD_US 200
`define BVS_MIN_OFF_NS 100
`define BVS_MIN_OFF_CYC ((`BVS_MIN_OFF_NS * `BVS_CLK_MHZ) / 1000)
`define BVS_ON_CYC 20
`define BVS_SLEW_BASE_CYC 16'd250
`define BVS_I2C_ADDR 7'h2a

`endif

// File: bvs_pkg.sv
// Types shared by the voltage select and slew control.
// Assumes bvs_params.svh is on the include path.
package bvs_pkg;
	typedef enum {I_IDLE, I_ADDR, I_AACK, I_REG, I_RACK, I_WR, I_WACK,
		I_RD, I_MACK} bvs_i2c_t;
	typedef enum {S_OFF, S_HIGH, S_LOW} bvs_sw_t;
	typedef struct packed {
		bvs_i2c_t i2c;
		logic [3:0] bitcnt;
		logic [7:0] shreg;
		logic [7:0] ptr;
		logic rnw;
		logic scl_p;
		logic sda_p;
		logic sda_oe;
		logic [7:0] rcfg;
		logic [7:0] irqa;
		logic [7:0] irqb;
		logic [7:0] irqc;
		logic [7:0] v0;
		logic [7:0] m0;
		logic [7:0] v1;
		logic [7:0] m1;
		logic [7:0] sel;
		logic [7:0] slew;
		logic [17:0] dcnt;
		logic rdone;
		logic [7:0] vref;
		logic [15:0] scnt;
		logic [15:0] hold;
		logic fpwm;
		logic conv_on;
		bvs_sw_t sw;
		logic [7:0] swcnt;
		logic hs;
		logic ls;
	} bvs_state_t;
endpackage

// File: bvs_ctrl.sv
// Voltage setting select, slew stepping, restore-default and switch timing.
// Assumes synchronous pin inputs; SDA resolved outside from sda_oe.
`timescale 1ns/10ps
`include "bvs_params.svh"

// Notes on behaviour
// - Restore pin low restores voltages and enables
// - Restore acts after debounce, at least 100us
// - Restore configuration reads zero after reset
// - Enable high runs, low shuts down
// - Two 8-bit voltage settings per converter
// - Setting zero at conv1_setting_zero_voltage, one at conv1_setting_one_voltage
// - Select 00 picks zero, 01 picks one
// - Select 10 follows the select pin
// - Polarity bit inverts pin to setting mapping
// - Up and down slew from slew fields
// - Slew applies to rewrites and switches
// - Forced PWM during ramp plus 200us
// - One-shot high side, then low side
// - New on-time after off, current, ramp
// - Debounce code 000 is shortest
// - Mode bit five selects forced continuous
module bvs_ctrl #(
	parameter int DBNC_CYC = `BVS_DBNC_TIME_US * `BVS_CLK_MHZ,
	parameter int PWM_HOLD_CYC = `BVS_PWM_HOLD_US * `BVS_CLK_MHZ
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic master_enable,
	input wire logic restore_default_n,
	input wire logic setting_select_pin,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic current_below_limit,
	input wire logic ramp_below_error,
	output logic high_side_switch,
	output logic low_side_switch,
	output logic [7:0] vref_code,
	output logic forced_pwm,
	output logic conv_on
);
	import bvs_pkg::*;
	bvs_state_t q;
	bvs_state_t d;
	logic rst_w;
	logic [7:0] target;
	logic [7:0] amode;
	logic use_one;
	logic [15:0] interval;
	logic [17:0] dthr;
	logic start_c;
	logic stop_c;
	logic rise_c;
	logic fall_c;
	// Shutdown returns all digital state to its reset values, like the reset
	assign rst_w = reset | ~master_enable;
	// ---------------------------------------------------------------
	// Register read mux
	// ---------------------------------------------------------------
	function automatic logic [7:0] rd_reg(input logic [7:0] a,
		input bvs_state_t s);
		case (a)
			`BVS_OFF_RESTORE_CFG: rd_reg = s.rcfg;
			`BVS_OFF_IRQ_CFG_A: rd_reg = s.irqa;
			`BVS_OFF_IRQ_CFG_B: rd_reg = s.irqb;
			`BVS_OFF_IRQ_CFG_C: rd_reg = s.irqc;
			`BVS_OFF_V0: rd_reg = s.v0;
			`BVS_OFF_MODE0: rd_reg = s.m0;
			`BVS_OFF_V1: rd_reg = s.v1;
			`BVS_OFF_MODE1: rd_reg = s.m1;
			`BVS_OFF_SEL: rd_reg = s.sel;
			`BVS_OFF_SLEW: rd_reg = s.slew;
			default: rd_reg = 8'h00;
		endcase
	endfunction
	// ---------------------------------------------------------------
	// Setting selection and slew interval
	// ---------------------------------------------------------------
	always_comb begin
		// One flag picks both voltage and mode, even if values match
		case (q.sel[1:0])
			`BVS_SEL_SW0: use_one = 1'b0;
			`BVS_SEL_SW1: use_one = 1'b1;
			// Pin only consulted in this mode
			`BVS_SEL_PIN: use_one = ~(setting_select_pin ^
				q.sel[`BVS_SEL_POL]);
			default: use_one = 1'b0;
		endcase
		target = use_one ? q.v1 : q.v0;
		amode = use_one ? q.m1 : q.m0;
		if (target > q.vref)
			interval = `BVS_SLEW_BASE_CYC << q.slew[6:4];
		else
			interval = `BVS_SLEW_BASE_CYC << q.slew[2:0];
		// Code 000 gives the base 100us, larger codes multiply it
		dthr = 18'(DBNC_CYC * (int'(q.rcfg[`BVS_RST_DBNC_MSB:0]) + 1));
	end
	assign start_c = scl & q.scl_p & q.sda_p & ~sda_in;
	assign stop_c = scl & q.scl_p & ~q.sda_p & sda_in;
	assign rise_c = scl & ~q.scl_p;
	assign fall_c = ~scl & q.scl_p;
	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		d = q;
		d.scl_p = scl;
		d.sda_p = sda_in;
		// I2C slave: register pointer then data, auto-increment
		if (start_c) begin
			d.i2c = I_ADDR;
			d.bitcnt = 4'h0;
			d.sda_oe = 1'b0;
		end else if (stop_c) begin
			d.i2c = I_IDLE;
			d.sda_oe = 1'b0;
		end else if (rise_c) begin
			case (q.i2c)
				I_ADDR, I_REG, I_WR: begin
					d.shreg = {q.shreg[6:0], sda_in};
					d.bitcnt = q.bitcnt + 4'h1;
				end
				I_MACK:
					if (sda_in)
						d.i2c = I_IDLE;
				default: d.bitcnt = q.bitcnt;
			endcase
		end else if (fall_c) begin
			case (q.i2c)
				I_ADDR: begin
					if (q.bitcnt == 4'h8) begin
						d.bitcnt = 4'h0;
						if (q.shreg[7:1] == `BVS_I2C_ADDR) begin
							d.rnw = q.shreg[0];
							d.sda_oe = 1'b1;
							d.i2c = I_AACK;
						end else begin
							d.i2c = I_IDLE;
						end
					end
				end
				I_REG: begin
					if (q.bitcnt == 4'h8) begin
						d.bitcnt = 4'h0;
						d.ptr = q.shreg;
						d.sda_oe = 1'b1;
						d.i2c = I_RACK;
					end
				end
				I_WR: begin
					if (q.bitcnt == 4'h8) begin
						d.bitcnt = 4'h0;
						d.ptr = q.ptr + 8'h01;
						d.sda_oe = 1'b1;
						d.i2c = I_WACK;
						case (q.ptr)
							`BVS_OFF_RESTORE_CFG: d.rcfg = q.shreg;
							`BVS_OFF_IRQ_CFG_A: d.irqa = q.shreg;
							`BVS_OFF_IRQ_CFG_B: d.irqb = q.shreg;
							`BVS_OFF_IRQ_CFG_C: d.irqc = q.shreg;
							`BVS_OFF_V0: d.v0 = q.shreg;
							`BVS_OFF_MODE0: d.m0 = q.shreg;
							`BVS_OFF_V1: d.v1 = q.shreg;
							`BVS_OFF_MODE1: d.m1 = q.shreg;
							`BVS_OFF_SEL: d.sel = q.shreg;
							`BVS_OFF_SLEW: d.slew = q.shreg;
							default: d.ptr = q.ptr + 8'h01;
						endcase
					end
				end
				I_AACK: begin
					if (q.rnw) begin
						d.shreg = rd_reg(q.ptr, q);
						d.sda_oe = ~d.shreg[7];
						d.i2c = I_RD;
					end else begin
						d.sda_oe = 1'b0;
						d.i2c = I_REG;
					end
				end
				I_RACK, I_WACK: begin
					d.sda_oe = 1'b0;
					d.i2c = I_WR;
				end
				I_RD: begin
					d.bitcnt = q.bitcnt + 4'h1;
					d.shreg = {q.shreg[6:0], 1'b0};
					d.sda_oe = ~q.shreg[6];
					if (q.bitcnt == 4'h7) begin
						d.bitcnt = 4'h0;
						d.sda_oe = 1'b0;
						d.i2c = I_MACK;
					end
				end
				I_MACK: begin
					d.ptr = q.ptr + 8'h01;
					d.shreg = rd_reg(q.ptr + 8'h01, q);
					d.sda_oe = ~d.shreg[7];
					d.i2c = I_RD;
				end
				default: d.i2c = I_IDLE;
			endcase
		end
		// Restore-default pin, debounced; acts once per low period
		if (restore_default_n) begin
			d.dcnt = 18'h0;
			d.rdone = 1'b0;
		end else if (!q.rdone) begin
			d.dcnt = q.dcnt + 18'h1;
			if (d.dcnt >= dthr) begin
				d.rdone = 1'b1;
				if (q.rcfg[`BVS_RST_CONV1_EN]) begin
					d.v0 = `BVS_V0_DEF;
					d.v1 = `BVS_V1_DEF;
					d.m0[`BVS_MODE_ENABLE] = 1'(`BVS_MODE_DEF >> `BVS_MODE_ENABLE);
					d.m1[`BVS_MODE_ENABLE] = 1'(`BVS_MODE_DEF >> `BVS_MODE_ENABLE);
					d.sel = `BVS_SEL_DEF;
				end
			end
		end
		// Reference stepping; interval restarts on each step
		if (q.vref != target) begin
			d.scnt = q.scnt + 16'h1;
			if (q.scnt >= interval - 16'h1) begin
				d.scnt = 16'h0;
				d.vref = (target > q.vref) ? q.vref + 8'h01 :
					q.vref - 8'h01;
			end
			d.hold = 16'(PWM_HOLD_CYC);
		end else begin
			d.scnt = 16'h0;
			if (q.hold != 16'h0)
				d.hold = q.hold - 16'h1;
		end
		d.fpwm = (q.vref != target) || (q.hold != 16'h0) ||
			amode[`BVS_MODE_FORCED_CONTINUOUS];
		d.conv_on = amode[`BVS_MODE_ENABLE];
		// Switch timing: one-shot on, then low side until retrigger
		case (q.sw)
			S_OFF: begin
				d.hs = 1'b0;
				d.ls = 1'b0;
				d.swcnt = 8'h0;
				if (q.conv_on)
					d.sw = S_LOW;
			end
			S_HIGH: begin
				d.swcnt = q.swcnt + 8'h1;
				if (q.swcnt >= 8'(`BVS_ON_CYC - 1)) begin
					d.hs = 1'b0;
					d.ls = 1'b1;
					d.swcnt = 8'h0;
					d.sw = S_LOW;
				end
			end
			S_LOW: begin
				if (q.swcnt < 8'(`BVS_MIN_OFF_CYC))
					d.swcnt = q.swcnt + 8'h1;
				if (!q.conv_on)
					d.sw = S_OFF;
				else if (q.swcnt >= 8'(`BVS_MIN_OFF_CYC) &&
					current_below_limit && ramp_below_error) begin
					d.hs = 1'b1;
					d.ls = 1'b0;
					d.swcnt = 8'h0;
					d.sw = S_HIGH;
				end
			end
			default: d.sw = S_OFF;
		endcase
		if (rst_w) begin
			// Zero is the idle code of both machines
			d = '0;
			d.scl_p = 1'b1;
			d.sda_p = 1'b1;
			d.rcfg = `BVS_RESTORE_CFG_RST;
			d.irqa = `BVS_IRQ_CFG_RST;
			d.irqb = `BVS_IRQ_CFG_RST;
			d.irqc = `BVS_IRQ_CFG_RST;
			d.v0 = `BVS_V0_DEF;
			d.v1 = `BVS_V1_DEF;
			d.m0 = `BVS_MODE_DEF;
			d.m1 = `BVS_MODE_DEF;
			d.sel = `BVS_SEL_DEF;
			d.slew = `BVS_SLEW_DEF;
			d.vref = `BVS_V0_DEF;
		end
	end

	always_ff @(posedge clk) begin
		q <= d;
	end
	assign sda_out = 1'b0;
	assign sda_oe = q.sda_oe;
	assign high_side_switch = q.hs;
	assign low_side_switch = q.ls;
	assign vref_code = q.vref;
	assign forced_pwm = q.fpwm;
	assign conv_on = q.conv_on;
	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst_w);
	property p_rcfg_zero;
		$fell(rst_w) |-> q.rcfg == 8'h00;
	endproperty
	a_rcfg_zero: assert property (p_rcfg_zero)
		else $error("restore config not zero after reset");
	property p_step_one;
		$changed(q.vref) |-> (q.vref == $past(q.vref) + 8'h01) ||
			(q.vref == $past(q.vref) - 8'h01);
	endproperty
	a_step_one: assert property (p_step_one)
		else $error("reference moved by more than one code");
	property p_pwm_ramp;
		(q.vref != target) |=> q.fpwm;
	endproperty
	a_pwm_ramp: assert property (p_pwm_ramp)
		else $error("not forced PWM during ramp");
	property p_hold_load;
		(q.vref != target) |=> q.hold == 16'(PWM_HOLD_CYC);
	endproperty
	a_hold_load: assert property (p_hold_load)
		else $error("PWM hold not reloaded");
	property p_ls_after_hs;
		$fell(q.hs) && q.conv_on |-> q.ls;
	endproperty
	a_ls_after_hs: assert property (p_ls_after_hs)
		else $error("low side not on after high side");
	property p_on_cond;
		$rose(q.hs) |-> $past(current_below_limit) &&
			$past(ramp_below_error) && $past(q.swcnt) >= 8'(`BVS_MIN_OFF_CYC);
	endproperty
	a_on_cond: assert property (p_on_cond)
		else $error("on-time started without conditions");
	property p_sel_one;
		q.sel[1:0] == 2'b01 |-> target == q.v1;
	endproperty
	a_sel_one: assert property (p_sel_one)
		else $error("select 01 not setting one");
	property p_pin_pol;
		q.sel[1:0] == 2'b10 && !q.sel[2] && setting_select_pin |->
			target == q.v0;
	endproperty
	a_pin_pol: assert property (p_pin_pol)
		else $error("pin polarity mapping wrong");
	property p_dbnc;
		$rose(q.rdone) |-> $past(q.dcnt) + 18'h1 >= 18'(DBNC_CYC);
	endproperty
	a_dbnc: assert property (p_dbnc)
		else $error("restore acted before debounce");
	property p_shutdown;
		disable iff (reset) !master_enable |=> !q.hs && !q.ls;
	endproperty
	a_shutdown: assert property (p_shutdown)
		else $error("switching during shutdown");

	c_ramp_up: cover property (q.vref != target ##1 q.vref == target);
	c_restore: cover property ($rose(q.rdone) && q.rcfg[`BVS_RST_CONV1_EN]);
	c_pulse: cover property ($rose(q.hs) ##[1:40] $rose(q.ls));
endmodule // bvs_ctrl

// File: bvs_i2c_host.sv
// I2C host model that reaches the registers of the voltage control.
// Assumes SDA is resolved outside with a pull-up; sda_low pulls it down.
`timescale 1ns/10ps
`include "bvs_params.svh"

module bvs_i2c_host (
	input wire logic clk,
	input wire logic sda_in,
	output logic scl,
	output logic sda_low
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// -------------------------------------------------
	// Bus tasks
	// -------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Halves of 3 to 4 clocks keep within the device's sampling
	task automatic put_bit(input logic b);
		sda_low = ~b;
		tick(3);
		scl = 1'b1;
		tick(4);
		scl = 1'b0;
		tick(1);
	endtask

	task automatic get_bit(output logic b);
		sda_low = 1'b0;
		tick(3);
		scl = 1'b1;
		tick(2);
		b = sda_in;
		tick(2);
		scl = 1'b0;
		tick(1);
	endtask

	task automatic start;
		sda_low = 1'b0;
		tick(3);
		scl = 1'b1;
		tick(4);
		sda_low = 1'b1;
		tick(4);
		scl = 1'b0;
		tick(1);
	endtask

	task automatic stop;
		sda_low = 1'b1;
		tick(3);
		scl = 1'b1;
		tick(4);
		sda_low = 1'b0;
		tick(4);
	endtask

	task automatic put_byte(input logic [7:0] v);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			put_bit(v[i]);
		end
		get_bit(a);
	endtask

	task automatic wr(input logic [7:0] r, input logic [7:0] v);
		start;
		put_byte({`BVS_I2C_ADDR, 1'b0});
		put_byte(r);
		put_byte(v);
		stop;
	endtask

	task automatic rd(input logic [7:0] r, output logic [7:0] v);
		start;
		put_byte({`BVS_I2C_ADDR, 1'b0});
		put_byte(r);
		start;
		put_byte({`BVS_I2C_ADDR, 1'b1});
		for (int i = 7; i >= 0; i--) begin
			get_bit(v[i]);
		end
		// No acknowledge, so the device stops sending
		put_bit(1'b1);
		stop;
	endtask

	task automatic irq_setup;
		wr(8'h33, 8'h40);
		wr(8'h34, 8'h40);
		wr(8'h35, 8'h40);
	endtask
endmodule // bvs_i2c_host

// File: buck_voltage_select_slew_ctrl_tb_top.sv
// Self-checking bench for the voltage select and slew control.
// Assumes bvs_i2c_host as bus host and shortened debounce and hold.
`timescale 1ns/10ps
`include "bvs_params.svh"

module buck_voltage_select_slew_ctrl_tb_top;
	logic clk, reset, master_enable, restore_default_n;
	logic setting_select_pin, scl, sda_low, sda_oe, sda_out;
	logic current_below_limit, ramp_below_error;
	logic high_side_switch, low_side_switch, forced_pwm, conv_on;
	logic [7:0] vref_code, res_data, d;
	logic [31:0] rnd;
	logic rand_on, cur_fix, rmp_fix, res_val;
	logic [7:0] exp_q[$];
	int bad_count, cmp_count, cyc, n;
	wire sda_w = ~(sda_low | sda_oe);

	bvs_ctrl #(.DBNC_CYC(50), .PWM_HOLD_CYC(100)) bvs_ctrl_inst (
		.clk(clk), .reset(reset), .master_enable(master_enable),
		.restore_default_n(restore_default_n),
		.setting_select_pin(setting_select_pin), .scl(scl),
		.sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
		.current_below_limit(current_below_limit),
		.ramp_below_error(ramp_below_error),
		.high_side_switch(high_side_switch),
		.low_side_switch(low_side_switch), .vref_code(vref_code),
		.forced_pwm(forced_pwm), .conv_on(conv_on));
	bvs_i2c_host bvs_i2c_host_inst (.clk(clk), .sda_in(sda_w),
		.scl(scl), .sda_low(sda_low));

	// -------------------------------------------------
	// Helpers
	// -------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] r, input logic [7:0] v);
		bvs_i2c_host_inst.wr(r, v);
	endtask
	task automatic rd(input logic [7:0] r, output logic [7:0] v);
		bvs_i2c_host_inst.rd(r, v);
	endtask
	task automatic obs(input logic [7:0] e, input logic [7:0] v);
		exp_q.push_back(e);
		@(posedge clk);
		#1;
		res_data = v;
		res_val = 1'b1;
		tick(1);
		res_val = 1'b0;
	endtask
	task automatic wait_for(input logic [7:0] t);
		int k;
		k = 0;
		// Three up steps at rate 1 take 1500 cycles
		while (k < 2000 && vref_code !== t) begin
			tick(1);
			k++;
		end
		obs(t, vref_code);
	endtask
	task automatic cmp_byte(input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic report_and_stop;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// -------------------------------------------------
	// Clock, random inputs, watcher, timeout
	// -------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Drives the loop inputs each cycle, random or from cur_fix and rmp_fix, which the scenario changes as it runs
	always @(posedge clk) begin
		#1;
		rnd = lfsr(rnd);
		current_below_limit = rand_on ? rnd[3] : cur_fix;
		ramp_below_error = rand_on ? rnd[7] : rmp_fix;
	end
	always @(posedge clk) begin
		if (res_val === 1'b1) begin
			cmp_byte(exp_q.pop_front(), res_data);
		end
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			bad_count++;
			report_and_stop;
		end
	end

	// -------------------------------------------------
	// Scenarios
	// -------------------------------------------------
	initial begin
		{reset, master_enable, restore_default_n} = 3'b111;
		{setting_select_pin, rand_on, cur_fix, rmp_fix} = 4'b1100;
		{current_below_limit, ramp_below_error, res_val} = 3'b000;
		res_data = 8'h00;
		rnd = 32'ha08f;
		tick(10);
		reset = 1'b0;
		tick(2);
		rd(8'h25, d);
		obs(8'h00, d);
		obs(`BVS_V0_DEF, vref_code);
		bvs_i2c_host_inst.irq_setup;
		rd(8'h35, d);
		obs(8'h40, d);
		$display("reset done");
		wr(8'h54, 8'h10);
		wr(8'h48, 8'h65);
		tick(400);
		obs(8'h64, vref_code);
		tick(150);
		obs(8'h65, vref_code);
		obs(8'h01, {7'h0, forced_pwm});
		tick(150);
		obs(8'h00, {7'h0, forced_pwm});
		wr(8'h49, 8'h21);
		obs(8'h01, {7'h0, forced_pwm});
		wr(8'h49, 8'h01);
		$display("slew done");
		wr(8'h4a, 8'h62);
		wr(8'h52, 8'h01);
		wait_for(8'h62);
		wr(8'h52, 8'h02);
		wait_for(8'h65);
		setting_select_pin = 1'b0;
		wait_for(8'h62);
		wr(8'h52, 8'h06);
		wait_for(8'h65);
		// Software select with polarity set: the pin is ignored, setting zero stays
		wr(8'h52, 8'h04);
		setting_select_pin = 1'b1;
		tick(600);
		obs(8'h65, vref_code);
		$display("select done");
		wr(8'h25, 8'h08);
		restore_default_n = 1'b0;
		tick(30);
		restore_default_n = 1'b1;
		tick(2);
		rd(8'h48, d);
		obs(8'h65, d);
		restore_default_n = 1'b0;
		tick(60);
		restore_default_n = 1'b1;
		tick(2);
		rd(8'h48, d);
		obs(`BVS_V0_DEF, d);
		rd(8'h4a, d);
		obs(`BVS_V1_DEF, d);
		wr(8'h48, 8'h66);
		wr(8'h25, 8'h09);
		restore_default_n = 1'b0;
		tick(70);
		restore_default_n = 1'b1;
		tick(2);
		rd(8'h48, d);
		obs(8'h66, d);
		$display("restore done");
		master_enable = 1'b0;
		tick(2);
		obs(8'h00, {7'h0, conv_on});
		master_enable = 1'b1;
		tick(3);
		obs(8'h01, {7'h0, conv_on});
		rd(8'h25, d);
		obs(8'h00, d);
		{rand_on, cur_fix, rmp_fix} = 3'b011;
		n = 0;
		while (n < 200 && high_side_switch !== 1'b1) begin
			tick(1);
			n++;
		end
		n = 0;
		while (n < 50 && high_side_switch === 1'b1) begin
			tick(1);
			n++;
		end
		obs(8'd20, n[7:0]);
		obs(8'h01, {7'h0, low_side_switch});
		cur_fix = 1'b0;
		tick(30);
		n = 0;
		repeat (100) begin
			tick(1);
			n = n + (high_side_switch === 1'b1);
		end
		obs(8'h00, n[7:0]);
		{cur_fix, rmp_fix} = 2'b10;
		tick(30);
		n = 0;
		repeat (100) begin
			tick(1);
			n = n + (high_side_switch === 1'b1);
		end
		obs(8'h00, n[7:0]);
		$display("switching done");
		report_and_stop;
	end
endmodule // buck_voltage_select_slew_ctrl_tb_top
